//--- aucp_pkg.sv
// package of constants and carrier types for the adc uart command port
package aucp_pkg;

    // ------------------------------------------------------------
    // command encodings and masks
    // ------------------------------------------------------------
    localparam logic [7:0] SYNC_WORD       = 8'h55;
    localparam logic [7:0] CMD_RESET       = 8'h06;
    localparam logic [7:0] CMD_START       = 8'h08;
    localparam logic [7:0] CMD_SLEEP       = 8'h02;
    localparam logic [7:0] MASK_LOW_BIT    = 8'hFE;
    localparam logic [3:0] CMD_RDATA_HI    = 4'h1;
    localparam logic [3:0] CMD_READ_REGISTER_CMD_HI     = 4'h2;
    localparam logic [3:0] CMD_WRITE_REGISTER_CMD_HI     = 4'h4;
    localparam logic [2:0] REG_LAST        = 3'h4;
    localparam logic [2:0] REG_GPIO        = 3'h4;
    localparam logic [7:0] REG_RESET_VAL   = 8'h00;
    localparam logic [7:0] UNMAPPED_VAL    = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CM_REG       = 1;
    localparam int CM_BIT       = 3;
    localparam int GPIO2DIR_BIT = 6;
    localparam int SEL_BIT      = 3;
    localparam int GPIO2DAT_BIT = 2;
    localparam int TURBO_BIT    = 4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 25_000_000;
    localparam int MOD_HZ_NORMAL   = 256_000;
    localparam int TOUT_MOD_NORMAL = 32760;
    localparam int TOUT_MOD_TURBO  = 65520;
    // normal: 32760 modulator periods at 256 kHz; turbo same time at 512k
    localparam longint TOUT_CYC_NORMAL =
        (longint'(TOUT_MOD_NORMAL) * CLK_HZ) / MOD_HZ_NORMAL;
    localparam longint TOUT_CYC_TURBO =
        (longint'(TOUT_MOD_TURBO) * CLK_HZ) / (2 * MOD_HZ_NORMAL);
    localparam int BAUD_W   = 16;
    localparam int TOUT_W   = 23;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        start_conv;
        logic        sleep;
        logic        reset_dev;
        logic        filter_restart;
    } aucp_ctl_type;

    typedef struct packed {
        logic        ready_n;
        logic        pin_out;
        logic        pin_oe;
    } aucp_pin_type;

endpackage

//--- aucp_top.sv
// uart command interpreter of a delta-sigma converter
//
// Behaviour
// - half duplex; transmit only in reply to a host command
// - transmit line idles high between bytes
// - bytes: low start bit, eight data bits lsb first, high stop
// - baud measured from every 55h sync byte, used for rx and tx
// - idle timeout mid command resets interface; same time in turbo, twice the modulator periods
// - results 24-bit two's complement, saturating at 7FFFFFh and 800000h
// - ready falls on new result, rises when latched for transmit
// - ready reaches shared pin only if output and selected
// - unread result: ready pulses high before next conversion completes
// - reset 0000011x, start 0000100x, sleep 0000001x, low bit ignored
// - read result 0001xxxx, register read 0010rrrx, write 0100rrrx
// - reset command restores defaults; host waits recovery delay
// - start begins single or continuous; mid conversion restarts filter
// - sleep after current conversion; registers kept; start wakes
// - read result loads latest result into shift register and sends
// - result landing during read command keeps ready low
// - words least significant byte first, bits lsb first
// - read of unimplemented register returns 00h
// - write stores byte, ignores bad address; non-04h restarts filter
// - commands act only once latched at mid stop bit
// - conversion mode bit in registers; start must follow a change
`timescale 1ns/1ps
module aucp_top
    import aucp_pkg::*;
#(
    parameter longint TOUT_NORMAL = TOUT_CYC_NORMAL,
    parameter longint TOUT_TURBO  = TOUT_CYC_TURBO
) (
    input  wire logic        ref_clk_in,
    input  wire logic        nrst_in,
    input  wire logic        clk_en_in,
    input  wire logic        rx_in,
    input  wire logic        turbo_in,
    input  wire logic        conv_busy_in,
    input  wire logic        conv_done_in,
    input  wire logic        ready_pulse_in,
    input  wire logic [23:0] conv_result_in,
    input  wire logic        shared_general_pin_in,
    output logic             tx_out,
    output logic [39:0]      config_out,
    output aucp_ctl_type     ctl_out,
    output logic             continuous_out,
    output logic             conversion_ready_n_out,
    output logic             shared_general_pin_out,
    output logic             shared_general_pin_oe_out,
    output logic             busy_out
);

    // ------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_SYNC = 5'b00001,
        ST_CMD  = 5'b00010,
        ST_DATA = 5'b00100,
        ST_SEND = 5'b01000,
        ST_WAIT = 5'b10000
    } aucp_state_type;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_BITS  = 4'b0100,
        RX_STOP  = 4'b1000
    } aucp_rx_type;

    aucp_state_type  st_ff,  nxt_st;
    aucp_rx_type     rxs_ff;
    logic [7:0]      regs_ff [0:4];
    logic [2:0]      addr_ff;
    logic [BAUD_W-1:0] baud_ff, bcnt_ff;
    logic [3:0]      edges_ff;
    logic [2:0]      bit_ff;
    logic [7:0]      shift_ff;
    logic            rx_prev_ff;
    logic            byte_vld_ff;
    logic [7:0]      byte_ff;
    logic [TOUT_W-1:0] tout_ff;
    logic [23:0]     result_ff;
    logic            ready_n_ff;
    logic            sleep_pend_ff;
    aucp_ctl_type    ctl_ff;

    // two-entry buffer on the transmit path
    logic [7:0]      buf_ff [0:1];
    logic [1:0]      buf_cnt_ff;
    logic            buf_rd_ff, buf_wr_ff;
    logic [1:0]      bytes_left_ff;
    logic [23:0]     word_ff;
    logic [9:0]      txsh_ff;
    logic [3:0]      txbit_ff;
    logic [BAUD_W-1:0] txcnt_ff;
    logic            tx_busy_ff;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic std_match(input logic [7:0] b,
                                       input logic [7:0] c);
        std_match = (b & MASK_LOW_BIT) == c;
    endfunction

    wire rx_fall   = rx_prev_ff & ~rx_in;
    wire half_hit  = bcnt_ff == {1'b0, baud_ff[BAUD_W-1:1]};
    wire full_hit  = bcnt_ff == baud_ff;
    wire is_reset  = std_match(byte_ff, CMD_RESET);
    wire is_start  = std_match(byte_ff, CMD_START);
    wire is_sleep  = std_match(byte_ff, CMD_SLEEP);
    wire is_rdata  = byte_ff[7:4] == CMD_RDATA_HI;
    wire is_read_register_cmd   = byte_ff[7:4] == CMD_READ_REGISTER_CMD_HI;
    wire is_write_register_cmd   = byte_ff[7:4] == CMD_WRITE_REGISTER_CMD_HI;
    wire [2:0] cmd_addr = byte_ff[3:1];
    wire addr_ok   = cmd_addr <= REG_LAST;
    wire [7:0] read_register_cmd_val = addr_ok ? regs_ff[cmd_addr]
                                  : UNMAPPED_VAL;
    wire push      = buf_cnt_ff != 2'd2 && bytes_left_ff != 2'd0;
    wire pop       = !tx_busy_ff && buf_cnt_ff != 2'd0;
    wire cmd_live  = st_ff == ST_CMD || st_ff == ST_DATA;
    wire tout_hit  = turbo_in ? tout_ff >= TOUT_W'(TOUT_TURBO)
                              : tout_ff >= TOUT_W'(TOUT_NORMAL);
    wire load_res  = byte_vld_ff && st_ff == ST_CMD && is_rdata;
    wire [7:0] cfg4 = regs_ff[REG_GPIO];

    // ------------------------------------------------------------
    // receiver with baud measurement
    // ------------------------------------------------------------
    // sync 55h gives 5 falling edges over 8 bit times: measure
    // from first start edge to 5th fall (8 bits), divide by 8
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rxs_ff      <= RX_IDLE;
            rx_prev_ff  <= 1'b1;
            bcnt_ff     <= '0;
            baud_ff     <= 16'h00D9;
            edges_ff    <= '0;
            bit_ff      <= '0;
            shift_ff    <= '0;
            byte_vld_ff <= 1'b0;
            byte_ff     <= '0;
        end else if (clk_en_in) begin
            rx_prev_ff  <= rx_in;
            byte_vld_ff <= 1'b0;
            if (st_ff == ST_SYNC) begin
                bcnt_ff <= bcnt_ff + 1'b1;
                if (rx_fall) begin
                    edges_ff <= edges_ff + 1'b1;
                    if (edges_ff == 4'd0) bcnt_ff <= '0;
                    if (edges_ff == 4'd4) begin
                        baud_ff  <= {3'h0, bcnt_ff[BAUD_W-1:3]};
                        edges_ff <= '0;
                        rxs_ff   <= RX_STOP;
                        bcnt_ff  <= '0;
                        bit_ff   <= '0;
                    end
                end
                if (rxs_ff == RX_STOP && bcnt_ff == baud_ff) begin
                    byte_vld_ff <= 1'b1;
                    byte_ff     <= SYNC_WORD;
                    rxs_ff      <= RX_IDLE;
                end
            end else begin
                bcnt_ff <= bcnt_ff + 1'b1;
                edges_ff <= '0;
                case (rxs_ff)
                    RX_IDLE: begin
                        bcnt_ff <= '0;
                        if (rx_fall) rxs_ff <= RX_START;
                    end
                    // start bit high again at mid point: a glitch
                    RX_START: if (half_hit) begin
                        bcnt_ff <= '0;
                        rxs_ff  <= rx_in ? RX_IDLE : RX_BITS;
                    end
                    RX_BITS: if (full_hit) begin
                        bcnt_ff  <= '0;
                        shift_ff <= {rx_in, shift_ff[7:1]};
                        bit_ff   <= bit_ff + 1'b1;
                        if (bit_ff == 3'd7) rxs_ff <= RX_STOP;
                    end
                    RX_STOP: if (full_hit) begin
                        rxs_ff      <= RX_IDLE;
                        byte_vld_ff <= rx_in;
                        byte_ff     <= shift_ff;
                    end
                    default: rxs_ff <= RX_IDLE;
                endcase
            end
            if (tout_hit) rxs_ff <= RX_IDLE;
        end
    end

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_SYNC: if (byte_vld_ff) nxt_st = ST_CMD;
            ST_CMD: if (byte_vld_ff) begin
                if (is_write_register_cmd)                  nxt_st = ST_DATA;
                else if (is_rdata || is_read_register_cmd) nxt_st = ST_SEND;
                else                          nxt_st = ST_SYNC;
            end
            ST_DATA: if (byte_vld_ff) nxt_st = ST_SYNC;
            ST_SEND: if (bytes_left_ff == 2'd0) nxt_st = ST_WAIT;
            ST_WAIT: if (!tx_busy_ff && buf_cnt_ff == 2'd0)
                nxt_st = ST_SYNC;
            default: nxt_st = ST_SYNC;
        endcase
        if (tout_hit) nxt_st = ST_SYNC;
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_ff   <= ST_SYNC;
            tout_ff <= '0;
        end else if (clk_en_in) begin
            st_ff   <= nxt_st;
            // idle timer: only a line resting high inside a command counts
            tout_ff <= (!cmd_live || !rx_in || byte_vld_ff) ? '0
                                                            : tout_ff + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers, control pulses, result and ready flag
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < 5; i++) regs_ff[i] <= REG_RESET_VAL;
            addr_ff       <= '0;
            ctl_ff        <= '0;
            sleep_pend_ff <= 1'b0;
            ready_n_ff    <= 1'b1;
            result_ff     <= '0;
        end else if (clk_en_in) begin
            ctl_ff <= '0;
            if (byte_vld_ff && st_ff == ST_CMD) begin
                addr_ff <= cmd_addr;
                if (is_reset) begin
                    for (int i = 0; i < 5; i++) regs_ff[i] <= REG_RESET_VAL;
                    ctl_ff.reset_dev <= 1'b1;
                    ready_n_ff       <= 1'b1;
                    sleep_pend_ff    <= 1'b0;
                end
                if (is_start) begin
                    ctl_ff.start_conv     <= 1'b1;
                    ctl_ff.filter_restart <= conv_busy_in;
                    sleep_pend_ff         <= 1'b0;
                end
                if (is_sleep) sleep_pend_ff <= 1'b1;
            end
            if (byte_vld_ff && st_ff == ST_DATA && addr_ff <= REG_LAST) begin
                regs_ff[addr_ff] <= byte_ff;
                if (addr_ff != REG_GPIO)
                    ctl_ff.filter_restart <= 1'b1;
            end
            if (sleep_pend_ff && !conv_busy_in) begin
                ctl_ff.sleep  <= 1'b1;
                sleep_pend_ff <= 1'b0;
            end
            // done together with a read: old word goes, flag stays low
            if (load_res) begin
                result_ff  <= conv_result_in;
                ready_n_ff <= conv_done_in ? 1'b0 : 1'b1;
            end else if (conv_done_in) ready_n_ff <= 1'b0;
            else if (ready_pulse_in && !ready_n_ff)
                ready_n_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // transmit buffer and serialiser
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            buf_ff[0]     <= '0;
            buf_ff[1]     <= '0;
            buf_cnt_ff    <= '0;
            buf_rd_ff     <= 1'b0;
            buf_wr_ff     <= 1'b0;
            bytes_left_ff <= '0;
            word_ff       <= '0;
            txsh_ff       <= 10'h3FF;
            txbit_ff      <= '0;
            txcnt_ff      <= '0;
            tx_busy_ff    <= 1'b0;
        end else if (clk_en_in) begin
            if (byte_vld_ff && st_ff == ST_CMD && is_rdata) begin
                word_ff       <= conv_result_in;
                bytes_left_ff <= 2'd3;
            end else if (byte_vld_ff && st_ff == ST_CMD && is_read_register_cmd) begin
                word_ff       <= {16'h0000, read_register_cmd_val};
                bytes_left_ff <= 2'd1;
            end else if (push) begin
                buf_ff[buf_wr_ff] <= word_ff[7:0];
                buf_wr_ff         <= ~buf_wr_ff;
                word_ff           <= {8'h00, word_ff[23:8]};
                bytes_left_ff     <= bytes_left_ff - 1'b1;
            end
            buf_cnt_ff <= buf_cnt_ff + {1'b0, push && !load_res}
                        - {1'b0, pop};
            // one idle cycle between bytes keeps the pop logic simple
            if (pop) begin
                txsh_ff    <= {1'b1, buf_ff[buf_rd_ff], 1'b0};
                buf_rd_ff  <= ~buf_rd_ff;
                tx_busy_ff <= 1'b1;
                txbit_ff   <= '0;
                txcnt_ff   <= '0;
            end else if (tx_busy_ff) begin
                txcnt_ff <= txcnt_ff + 1'b1;
                if (txcnt_ff == baud_ff) begin
                    txcnt_ff <= '0;
                    txsh_ff  <= {1'b1, txsh_ff[9:1]};
                    txbit_ff <= txbit_ff + 1'b1;
                    if (txbit_ff == 4'd9) tx_busy_ff <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign tx_out = tx_busy_ff ? txsh_ff[0] : 1'b1;
    assign config_out = {regs_ff[4], regs_ff[3], regs_ff[2],
                         regs_ff[1], regs_ff[0]};
    assign ctl_out = ctl_ff;
    assign continuous_out = regs_ff[CM_REG][CM_BIT];
    assign conversion_ready_n_out = ready_n_ff;
    assign shared_general_pin_oe_out = cfg4[GPIO2DIR_BIT];
    assign shared_general_pin_out = cfg4[SEL_BIT] ? ready_n_ff
                                   : cfg4[GPIO2DAT_BIT];
    assign busy_out = st_ff != ST_SYNC;

endmodule // aucp_top

//--- aucp_monitor.sv
// checker of the uart command port outputs
`timescale 1ns/1ps
module aucp_monitor
    import aucp_pkg::*;
#(
    parameter longint TOUT_NORMAL = 2000,
    parameter longint TOUT_TURBO  = 4000
) (
    input wire logic         ref_clk_in,
    input wire logic         nrst_in,
    input wire logic         conv_done_in,
    input wire logic         ready_pulse_in,
    input wire logic         tx_out,
    input wire logic [39:0]  config_out,
    input wire aucp_ctl_type ctl_out,
    input wire logic         continuous_out,
    input wire logic         conversion_ready_n_out,
    input wire logic         shared_general_pin_out,
    input wire logic         shared_general_pin_oe_out,
    input wire logic         busy_out
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    AST_TX_REPLY: assert property ($fell(tx_out) |-> busy_out)
        else $error("tx start bit outside a command");
    AST_PIN_OE: assert property (
        shared_general_pin_oe_out == config_out[38])
        else $error("pin enable not from direction bit");
    AST_PIN_READY: assert property (
        config_out[35] |-> shared_general_pin_out == conversion_ready_n_out)
        else $error("pin does not carry ready flag");
    AST_PIN_GPIO: assert property (
        !config_out[35] |-> shared_general_pin_out == config_out[34])
        else $error("pin does not carry data bit");
    AST_MODE_BIT: assert property (
        continuous_out == config_out[11])
        else $error("mode bit mismatch");
    AST_READY_SET: assert property (
        conv_done_in |=> !conversion_ready_n_out)
        else $error("ready flag not low after new result");
    AST_READY_PULSE: assert property (
        ready_pulse_in && !conv_done_in |=> conversion_ready_n_out)
        else $error("ready flag not pulsed high");
    AST_CTL_PULSE: assert property (
        $rose(ctl_out.start_conv) |=> !ctl_out.start_conv)
        else $error("start pulse longer than one cycle");
    AST_RESET_CMD: assert property (
        ctl_out.reset_dev |-> ##[0:2] config_out == 40'h0)
        else $error("registers not cleared by reset command");

    COV_START: cover property (ctl_out.start_conv);
    COV_READY: cover property (!conversion_ready_n_out ##1
                               conversion_ready_n_out);
    COV_TX: cover property ($fell(tx_out));
endmodule // aucp_monitor

bind aucp_top aucp_monitor #(
    .TOUT_NORMAL(TOUT_NORMAL),
    .TOUT_TURBO (TOUT_TURBO)
) mon_u (
    .ref_clk_in               (ref_clk_in),
    .nrst_in                  (nrst_in),
    .conv_done_in             (conv_done_in),
    .ready_pulse_in           (ready_pulse_in),
    .tx_out                   (tx_out),
    .config_out               (config_out),
    .ctl_out                  (ctl_out),
    .continuous_out           (continuous_out),
    .conversion_ready_n_out   (conversion_ready_n_out),
    .shared_general_pin_out   (shared_general_pin_out),
    .shared_general_pin_oe_out(shared_general_pin_oe_out),
    .busy_out                 (busy_out)
);

//--- aucp_host_model.sv
// host side uart model: drives rx, reads tx
`timescale 1ns/1ps
module aucp_host_model #(
    parameter int BIT_CYC = 16
) (
    input  wire logic clk_in,
    input  wire logic tx_in,
    output logic      rx_out
);
    // rx idles high, as the line pull-up would leave it
    initial rx_out = 1'h1;

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++) begin
            rx_out <= f[i];
            repeat (BIT_CYC) @(posedge clk_in);
        end
    endtask

    // sync first, then command, operand only for writes
    task automatic send_cmd(input logic [7:0] c, input logic [7:0] d,
                            input bit two);
        send_byte(8'h55);
        send_byte(c);
        if (two) send_byte(d);
    endtask

    // host stays silent while it waits for the reply
    task automatic recv_byte(output logic [7:0] b, output bit ok);
        int n;
        ok = 1'b0;
        b = 8'h00;
        n = 0;
        while (tx_in !== 1'h0 && n < 3000) begin
            @(posedge clk_in);
            n++;
        end
        if (tx_in === 1'h0) begin
            repeat (BIT_CYC / 2) @(posedge clk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge clk_in);
                b[i] = tx_in;
            end
            repeat (BIT_CYC) @(posedge clk_in);
            ok = (tx_in === 1'h1);
        end
    endtask
endmodule // aucp_host_model

//--- aucp_top_tb.sv
// self-checking bench of the uart command port
`timescale 1ns/1ps
`define CHK_EQ(a, e, m) begin compares++; if ((a) !== (e)) begin \
    miscompares++; $display("CHECK FAILED at %0t: %s", $time, m); end end
module aucp_top_tb;
    import aucp_pkg::*;
    localparam int TOUT  = 2000;
    localparam int RCV   = 200; // recovery wait, arbitrary
    localparam int LIMIT = 40000;
    logic         ref_clk_in = 1'h0;
    logic         nrst_in, clk_en, rx, turbo, cbusy, cdone, rpulse, shared_general_pin;
    logic [23:0]  cres;
    logic         tx, cont, rdy_n, pin, pin_oe, busy;
    logic [39:0]  cfg;
    aucp_ctl_type ctl;
    logic [7:0]   b;
    bit           ok;
    int           miscompares = 0, compares = 0, cyc = 0;
    int           n_st = 0, n_sl = 0, n_rs = 0, n_fr = 0;

    aucp_top #(.TOUT_NORMAL(TOUT), .TOUT_TURBO(2 * TOUT)) dut_u (
        .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en),
        .rx_in(rx), .turbo_in(turbo), .conv_busy_in(cbusy),
        .conv_done_in(cdone), .ready_pulse_in(rpulse),
        .conv_result_in(cres), .shared_general_pin_in(shared_general_pin), .tx_out(tx),
        .config_out(cfg), .ctl_out(ctl), .continuous_out(cont),
        .conversion_ready_n_out(rdy_n), .shared_general_pin_out(pin),
        .shared_general_pin_oe_out(pin_oe), .busy_out(busy));
    aucp_host_model #(.BIT_CYC(16)) host_u (
        .clk_in(ref_clk_in), .tx_in(tx), .rx_out(rx));

    always #20 ref_clk_in = ~ref_clk_in;
    // ------------------------------------------------------------
    // pulse counters, sampled away from the launching edge
    // ------------------------------------------------------------
    always @(negedge ref_clk_in) begin
        cyc++;
        n_st += int'(ctl.start_conv === 1'h1);
        n_sl += int'(ctl.sleep === 1'h1);
        n_rs += int'(ctl.reset_dev === 1'h1);
        n_fr += int'(ctl.filter_restart === 1'h1);
        if (cyc == LIMIT) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic idle();
        for (int n = 0; n < 3000 && busy !== 1'h0; n++) @(posedge ref_clk_in);
        repeat (4) @(posedge ref_clk_in);
    endtask
    task automatic cmd(input logic [7:0] c);
        host_u.send_cmd(c, 8'h00, 1'b0);
        idle();
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        host_u.send_cmd({CMD_WRITE_REGISTER_CMD_HI, a, 1'h0}, d, 1'b1);
        idle();
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        host_u.send_cmd({CMD_READ_REGISTER_CMD_HI, a, 1'h0}, 8'h00, 1'b0);
        host_u.recv_byte(b, ok);
        `CHK_EQ(ok, 1'b1, "reply framing")
        `CHK_EQ(b, e, "register read")
        idle();
    endtask

    initial begin
        nrst_in = 1'h0; clk_en = 1'h1; turbo = 1'h0; cbusy = 1'h0;
        cdone = 1'h0; rpulse = 1'h0; shared_general_pin = 1'h0; cres = 24'h0;
        repeat (8) @(posedge ref_clk_in);
        `CHK_EQ(tx, 1'h1, "tx idle")
        `CHK_EQ({cfg, rdy_n, pin_oe}, 42'h2, "reset state")
        nrst_in <= 1'h1;
        repeat (2) @(posedge ref_clk_in);
        wr(3'h1, 8'h08);
        `CHK_EQ(cont, 1'h1, "mode bit")
        `CHK_EQ(n_fr, 1, "write restarts filter")
        wr(3'h4, 8'h48);
        `CHK_EQ(n_fr, 1, "pin register no restart")
        `CHK_EQ(pin_oe, 1'h1, "pin enabled")
        wr(3'h5, 8'hFF);
        `CHK_EQ(cfg, 40'h4800000800, "bad address write")
        rd(3'h1, 8'h08);
        rd(3'h6, 8'h00);
        $display("test registers done");
        for (int k = 0; k < 2; k++) begin
            cmd(CMD_START | k[7:0]);
            cmd(CMD_SLEEP | k[7:0]);
        end
        `CHK_EQ({n_st, n_sl}, {32'd2, 32'd2}, "start and sleep")
        cmd(8'h30);
        `CHK_EQ({n_st, n_sl, n_rs}, {32'd2, 32'd2, 32'd0}, "skip")
        `CHK_EQ(cfg, 40'h4800000800, "registers kept")
        cbusy <= 1'h1;
        cmd(CMD_START);
        `CHK_EQ({n_st, n_fr}, {32'd3, 32'd2}, "mid conversion")
        cmd(CMD_SLEEP);
        `CHK_EQ(n_sl, 2, "sleep held")
        cbusy <= 1'h0;
        repeat (2) @(posedge ref_clk_in);
        `CHK_EQ(n_sl, 3, "sleep after conversion")
        $display("test commands done");
        cres <= 24'h800000;
        cdone <= 1'h1;
        @(posedge ref_clk_in);
        cdone <= 1'h0;
        repeat (2) @(posedge ref_clk_in);
        `CHK_EQ({rdy_n, pin}, 2'h0, "ready low on pin")
        rpulse <= 1'h1;
        @(posedge ref_clk_in);
        rpulse <= 1'h0;
        repeat (2) @(posedge ref_clk_in);
        `CHK_EQ(rdy_n, 1'h1, "unread pulse high")
        cdone <= 1'h1;
        @(posedge ref_clk_in);
        cdone <= 1'h0;
        repeat (2) @(posedge ref_clk_in);
        `CHK_EQ(rdy_n, 1'h0, "ready low again")
        host_u.send_cmd(8'h1F, 8'h00, 1'b0);
        for (int i = 0; i < 3; i++) begin
            host_u.recv_byte(b, ok);
            `CHK_EQ(b, (i == 2) ? 8'h80 : 8'h00, "byte")
        end
        idle();
        `CHK_EQ(rdy_n, 1'h1, "ready high after load")
        $display("test result done");
        host_u.send_byte(8'h55);
        repeat (TOUT / 2) @(posedge ref_clk_in);
        `CHK_EQ(busy, 1'h1, "waiting for command")
        repeat (TOUT) @(posedge ref_clk_in);
        `CHK_EQ(busy, 1'h0, "interface timed out")
        rd(3'h1, 8'h08);
        turbo <= 1'h1;
        host_u.send_byte(8'h55);
        repeat (3 * TOUT / 2) @(posedge ref_clk_in);
        `CHK_EQ(busy, 1'h1, "turbo still waiting")
        repeat (TOUT) @(posedge ref_clk_in);
        `CHK_EQ(busy, 1'h0, "turbo timed out")
        turbo <= 1'h0;
        rd(3'h1, 8'h08);
        $display("test timeout done");
        host_u.send_cmd(CMD_RESET | 8'h01, 8'h00, 1'b0);
        repeat (RCV) @(posedge ref_clk_in);
        `CHK_EQ({cfg, n_rs}, {40'h0, 32'd1}, "reset command")
        rd(3'h1, 8'h00);
        $display("test reset done");
        conclude();
    end
endmodule // aucp_top_tb
